// ==== verilog/qct_defines.svh ====
// Purpose: Constants for the chip select timing option block
// Assumes: 250 MHz system clock, 4 ns period
// Notes: Delay table is held in serial clock half periods
`ifndef QCT_DEFINES_SVH
`define QCT_DEFINES_SVH

// Register byte addresses
`define QCT_ADDR_OPT0 8'h00
`define QCT_ADDR_OPT3 8'h03
`define QCT_ADDR_CTRL 8'h04
`define QCT_ADDR_TX 8'h05
`define QCT_ADDR_STATUS 8'h06
`define QCT_ADDR_RX 8'h07

// Option register fields
`define QCT_OPT_GAP_HI 5
`define QCT_OPT_GAP_LO 3
`define QCT_OPT_LEAD_HI 2
`define QCT_OPT_LEAD_LO 0
`define QCT_OPT_RESET 8'h00

// Control register fields
`define QCT_CTRL_EXT 0
`define QCT_CTRL_SLAVE 1
`define QCT_CTRL_ENABLE 2
`define QCT_CTRL_RESET 3'h0

// Transmit register fields
`define QCT_TX_CS_HI 9
`define QCT_TX_CS_LO 8

// Half periods per delay code 7..0: 16,12,8,6,4,2,1,0
`define QCT_HALF_TABLE 64'h100C080604020100
`define QCT_HALF_EXT_CODE0 5'h01

// Serial clock half period: time in ns and derived cycle count
`define QCT_HALF_PERIOD_NS 20
`define QCT_CLK_PERIOD_NS 4
`define QCT_HALF_CYCLES (`QCT_HALF_PERIOD_NS / `QCT_CLK_PERIOD_NS)
`define QCT_BITS_HALVES 5'h10
`define QCT_CS_IDLE 4'hF

`endif

// ==== verilog/qct_pkg.sv ====
// Purpose: Types and shared decode for the chip select timing block
// Assumes: qct_defines.svh supplies the numeric constants
// Notes: Used by name only, never imported
`include "qct_defines.svh"

package qct_pkg;

    // Sequencer states, one-hot
    typedef enum logic [3:0] {
        QCT_IDLE  = 4'h1,
        QCT_LEAD  = 4'h2,
        QCT_SHIFT = 4'h4,
        QCT_GAP   = 4'h8
    } qct_state_t;

    // Delay code to serial clock half periods
    function automatic logic [4:0] qct_halves(input logic [2:0] code);
        logic [63:0] table_v;
        table_v = `QCT_HALF_TABLE;
        qct_halves = table_v[{code, 3'h0} +: 5];
    endfunction : qct_halves

endpackage : qct_pkg

// ==== verilog/qct_timer_if.sv ====
// Purpose: Link between the sequencer and its delay timer
// Assumes: One clock domain
// Notes: Counts are in serial clock half periods
`timescale 1ns/1ps

interface qct_timer_if;
    logic start;
    logic [4:0] halves;
    logic tick;
    logic expired;

    modport ctrl (output start, output halves, output tick, input expired);
    modport timer (input start, input halves, input tick, output expired);
endinterface : qct_timer_if

// ==== verilog/qct_delay_timer.sv ====
// Purpose: Counts a programmed number of serial clock half periods
// Assumes: tick pulses once per half period
// Notes: expired is valid the cycle after start
`timescale 1ns/1ps

module qct_delay_timer (
    input wire logic clock,
    input wire logic sys_rst,
    qct_timer_if.timer tif
);
    logic [4:0] count_reg;

    // Load on start, then count down on half period ticks
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            count_reg <= 5'h00;
        end else if (tif.start) begin
            count_reg <= tif.halves;
        end else if (tif.tick && count_reg != 5'h00) begin
            count_reg <= count_reg - 5'h01;
        end
    end

    assign tif.expired = (count_reg == 5'h00) && !tif.start;
endmodule : qct_delay_timer

// ==== verilog/qct_cs_timing.sv ====
// Purpose: Serial master sequencer with per chip select lead and gap delays
// Assumes: Plain register port, reads answered one cycle later
// Notes: Single holding word for transmit, mode 0 serial clock
//
// Added by the designer: the placing of the registers and strobed register access.
`timescale 1ns/1ps
`include "qct_defines.svh"

module qct_cs_timing (
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic [7:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [15:0] reg_rdata,
    input wire logic serial_data_in,
    output logic serial_data_out,
    output logic serial_clock_line_out,
    output logic serial_clock_line_oe,
    output logic [3:0] cs_n_out
);
    logic [7:0] opt_reg [4];
    logic [2:0] ctrl_reg;
    logic [9:0] tx_reg;
    logic tx_pend_reg;
    logic [7:0] rx_reg;
    logic [7:0] shift_reg;
    logic [1:0] cur_cs_reg;
    logic [4:0] half_cnt_reg;
    logic [7:0] presc_reg;
    logic tick_reg;
    qct_pkg::qct_state_t state_reg;
    qct_pkg::qct_state_t state_next;
    logic take;
    logic [4:0] lead_halves;
    logic [4:0] gap_halves;
    logic [2:0] gap_code;
    logic slave_mode;
    logic enabled;

    qct_timer_if tif ();

    qct_delay_timer u_timer (
        .clock(clock),
        .sys_rst(sys_rst),
        .tif(tif)
    );

    assign slave_mode = ctrl_reg[`QCT_CTRL_SLAVE];
    assign enabled = ctrl_reg[`QCT_CTRL_ENABLE] && !slave_mode;

    // Decode of the lead option from the pending element's chip select and the gap option from the current chip select
    always_comb begin
        lead_halves = qct_pkg::qct_halves(
            opt_reg[tx_reg[`QCT_TX_CS_HI:`QCT_TX_CS_LO]][`QCT_OPT_LEAD_HI:`QCT_OPT_LEAD_LO]);
        gap_code = opt_reg[cur_cs_reg][`QCT_OPT_GAP_HI:`QCT_OPT_GAP_LO];
        gap_halves = qct_pkg::qct_halves(gap_code);
        if (ctrl_reg[`QCT_CTRL_EXT] && gap_code == 3'h0) begin
            gap_halves = `QCT_HALF_EXT_CODE0;
        end
    end

    // Half period tick; all delays counted in serial clock units
    always_ff @(posedge clock) begin
        if (sys_rst || !enabled) begin
            presc_reg <= 8'h00;
            tick_reg <= 1'b0;
        end else if (presc_reg == 8'(`QCT_HALF_CYCLES - 1)) begin
            presc_reg <= 8'h00;
            tick_reg <= 1'b1;
        end else begin
            presc_reg <= presc_reg + 8'h01;
            tick_reg <= 1'b0;
        end
    end

    assign tif.tick = tick_reg;

    // Sequencer next state and timer loads
    always_comb begin
        state_next = state_reg;
        take = 1'b0;
        tif.start = 1'b0;
        tif.halves = 5'h00;
        case (state_reg)
            qct_pkg::QCT_IDLE: begin
                if (enabled && tx_pend_reg) begin
                    take = 1'b1;
                    tif.start = 1'b1;
                    tif.halves = lead_halves;
                    state_next = qct_pkg::QCT_LEAD;
                end
            end
            qct_pkg::QCT_LEAD: begin
                if (!enabled) begin
                    state_next = qct_pkg::QCT_IDLE;
                end else if (tif.expired) begin
                    state_next = qct_pkg::QCT_SHIFT;
                end
            end
            qct_pkg::QCT_SHIFT: begin
                if (!enabled) begin
                    state_next = qct_pkg::QCT_IDLE;
                end else if (tick_reg && half_cnt_reg == 5'h01) begin
                    tif.start = 1'b1;
                    tif.halves = gap_halves;
                    state_next = qct_pkg::QCT_GAP;
                end
            end
            qct_pkg::QCT_GAP: begin
                if (!enabled) begin
                    state_next = qct_pkg::QCT_IDLE;
                end else if (tif.expired && tx_pend_reg) begin
                    if (tx_reg[`QCT_TX_CS_HI:`QCT_TX_CS_LO] == cur_cs_reg) begin
                        take = 1'b1;
                        state_next = qct_pkg::QCT_SHIFT;
                    end else begin
                        state_next = qct_pkg::QCT_IDLE; // New select needs its lead
                    end
                end // otherwise hold select and stretch the gap
            end
            default: state_next = qct_pkg::QCT_IDLE;
        endcase
    end

    // State register
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            state_reg <= qct_pkg::QCT_IDLE;
        end else begin
            state_reg <= state_next;
        end
    end

    // Register writes; a new write wins over the take in the same cycle
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            for (int i = 0; i < 4; i++) begin
                opt_reg[i] <= `QCT_OPT_RESET;
            end
            ctrl_reg <= `QCT_CTRL_RESET;
            tx_reg <= 10'h000;
            tx_pend_reg <= 1'b0;
        end else begin
            if (reg_wr && reg_addr <= `QCT_ADDR_OPT3) begin
                opt_reg[reg_addr[1:0]] <= reg_wdata[7:0];
            end
            if (reg_wr && reg_addr == `QCT_ADDR_CTRL) begin
                ctrl_reg <= reg_wdata[2:0];
            end
            if (reg_wr && reg_addr == `QCT_ADDR_TX) begin
                tx_reg <= reg_wdata[9:0];
                tx_pend_reg <= 1'b1;
            end else if (take) begin
                tx_pend_reg <= 1'b0;
            end
        end
    end

    // Shifter, bit timing and receive capture, mode 0
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            shift_reg <= 8'h00;
            half_cnt_reg <= 5'h00;
            rx_reg <= 8'h00;
            cur_cs_reg <= 2'h0;
            serial_clock_line_out <= 1'b0;
            serial_data_out <= 1'b0;
        end else if (take) begin
            shift_reg <= tx_reg[7:0];
            serial_data_out <= tx_reg[7];
            cur_cs_reg <= tx_reg[`QCT_TX_CS_HI:`QCT_TX_CS_LO];
            half_cnt_reg <= `QCT_BITS_HALVES;
            serial_clock_line_out <= 1'b0;
        end else if (state_reg == qct_pkg::QCT_SHIFT && tick_reg && enabled) begin
            half_cnt_reg <= half_cnt_reg - 5'h01;
            serial_clock_line_out <= !serial_clock_line_out;
            if (!serial_clock_line_out) begin
                shift_reg <= {shift_reg[6:0], serial_data_in}; // Sample on rise
            end else begin
                serial_data_out <= shift_reg[7]; // Launch on fall
            end
            if (half_cnt_reg == 5'h01) begin
                rx_reg <= shift_reg; // Last rise already shifted the final bit in
            end
        end else if (state_reg != qct_pkg::QCT_SHIFT || !enabled) begin
            serial_clock_line_out <= 1'b0; // Cut frame parks the clock low with select
        end
    end

    // Chip select and clock enable; slave mode leaves both released
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            cs_n_out <= `QCT_CS_IDLE;
            serial_clock_line_oe <= 1'b0;
        end else begin
            serial_clock_line_oe <= !slave_mode;
            cs_n_out <= `QCT_CS_IDLE;
            if (state_next != qct_pkg::QCT_IDLE && enabled) begin
                cs_n_out[take ? tx_reg[`QCT_TX_CS_HI:`QCT_TX_CS_LO] : cur_cs_reg] <= 1'b0;
            end
        end
    end

    // Read data, one cycle after the strobe; unmapped reads zero
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            reg_rdata <= 16'h0000;
        end else if (reg_rd) begin
            if (reg_addr <= `QCT_ADDR_OPT3) begin
                reg_rdata <= {8'h00, opt_reg[reg_addr[1:0]]};
            end else if (reg_addr == `QCT_ADDR_CTRL) begin
                reg_rdata <= {13'h0000, ctrl_reg};
            end else if (reg_addr == `QCT_ADDR_TX) begin
                reg_rdata <= {6'h00, tx_reg};
            end else if (reg_addr == `QCT_ADDR_STATUS) begin
                reg_rdata <= {8'h00, state_reg, 2'h0, tx_pend_reg,
                    state_reg != qct_pkg::QCT_IDLE};
            end else if (reg_addr == `QCT_ADDR_RX) begin
                reg_rdata <= {8'h00, rx_reg};
            end else begin
                reg_rdata <= 16'h0000;
            end
        end else begin
            reg_rdata <= 16'h0000;
        end
    end
endmodule : qct_cs_timing

// ==== verif/qct_cs_timing_assertions.sv ====
// Purpose: Port checks for the chip select timing block
// Assumes: Sees only the top module ports
// Notes: Bound at the foot of this file
`timescale 1ns/1ps

module qct_cs_timing_assertions (
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic reg_rd,
    input wire logic [15:0] reg_rdata,
    input wire logic serial_data_out,
    input wire logic serial_clock_line_out,
    input wire logic serial_clock_line_oe,
    input wire logic [3:0] cs_n_out
);
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (sys_rst);
    // One serial half period is five system cycles
    sequence s_high_half;
        serial_clock_line_out [*5];
    endsequence
    a_half_width: assert property ($rose(serial_clock_line_out) |->
        s_high_half ##1 !serial_clock_line_out) else $error("serial clock half wrong");
    a_rdata_quiet: assert property (!$past(reg_rd) |-> reg_rdata == 16'h0000)
        else $error("read data outside its cycle");
    a_slave_quiet: assert property (!serial_clock_line_oe |->
        cs_n_out == 4'hF && !serial_clock_line_out) else $error("outputs active unselected");
    a_one_select: assert property ($countones(~cs_n_out) <= 1)
        else $error("several chip selects low");
    a_clock_framed: assert property ($rose(serial_clock_line_out) |-> cs_n_out != 4'hF)
        else $error("serial clock outside frame");
    a_cs_steady: assert property (serial_clock_line_out |-> $stable(cs_n_out))
        else $error("chip select moved in clock high");
    a_data_on_low: assert property ($changed(serial_data_out) |-> !serial_clock_line_out)
        else $error("data changed with clock high");
    a_release_low: assert property ($rose(&cs_n_out) |-> !serial_clock_line_out)
        else $error("clock high at deselect");
endmodule : qct_cs_timing_assertions

bind qct_cs_timing qct_cs_timing_assertions chk_u (.clock(clock), .sys_rst(sys_rst),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .serial_data_out(serial_data_out),
    .serial_clock_line_out(serial_clock_line_out),
    .serial_clock_line_oe(serial_clock_line_oe), .cs_n_out(cs_n_out));

// ==== verif/qct_slave_model.sv ====
// Purpose: Serial slave behind the chip selects
// Assumes: Mode 0, MSB first, any low select addresses it
// Notes: Released line flips so stale sampling shows up
`timescale 1ns/1ps

module qct_slave_model (
    input wire logic [3:0] cs_n,
    input wire logic sclk,
    input wire logic mosi,
    input wire logic [7:0] reply,
    output logic miso,
    output logic [7:0] got
);
    logic [7:0] shift;
    int bits = 0;
    initial miso = 1'b0;
    initial got = 8'h00;
    // First bit stands before the first rise
    always @(negedge (&cs_n)) begin
        shift = reply;
        bits = 0;
        miso = reply[7];
    end
    always @(posedge (&cs_n)) miso = ~miso;
    // Sample on rise, shift on fall, reload per element
    always @(posedge sclk) begin
        got = {got[6:0], mosi};
        bits++;
    end
    always @(negedge sclk) begin
        shift = (bits == 8) ? reply : {shift[6:0], 1'b0};
        bits = (bits == 8) ? 0 : bits;
        miso = shift[7];
    end
endmodule : qct_slave_model

// ==== verif/qct_cs_timing_tb.sv ====
// Purpose: Self-checking bench for the chip select timing block
// Assumes: 250 MHz clock, slave model on the serial side
// Notes: Delays compared to the code 0 run, since tick alignment blurs them
`timescale 1ns/1ps
`include "qct_defines.svh"

module qct_cs_timing_tb;
    `define CHK(g, e) begin compares++; if ((g) !== (e)) begin mismatches++; \
        $display("wrong value at %0t: got %h exp %h", $time, g, e); end end
    logic clock = 1'b0, sys_rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
    logic sdi, sdo, sck, oe, sck_q = 1'b0, cs_q = 1'b1;
    logic [7:0] reg_addr = 8'h00, reply = 8'h00, got, d;
    logic [15:0] reg_wdata = 16'h0000, reg_rdata, v;
    logic [3:0] cs_n;
    int mismatches = 0, compares = 0, cyc = 0, t_cs, t_fall, nrise, lead_cy, gap_cy, bl, bg;
    always #2 clock = ~clock;
    qct_cs_timing dut_u (.clock(clock), .sys_rst(sys_rst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .serial_data_in(sdi), .serial_data_out(sdo), .serial_clock_line_out(sck),
        .serial_clock_line_oe(oe), .cs_n_out(cs_n));
    qct_slave_model far_u (.cs_n(cs_n), .sclk(sck), .mosi(sdo), .reply(reply), .miso(sdi),
        .got(got));
    // Lead runs from select to first rise, gap from last fall to next rise
    always @(posedge clock) begin
        cyc++;
        sck_q <= sck;
        cs_q <= &cs_n;
        if (cs_q && !(&cs_n)) t_cs = cyc;
        if (sck_q && !sck) t_fall = cyc;
        if (!sck_q && sck) begin
            if (nrise == 0) lead_cy = cyc - t_cs;
            if (nrise == 8) gap_cy = cyc - t_fall;
            nrise++;
        end
    end
    function automatic int halves(input int c);
        int t[8] = '{0, 1, 2, 4, 6, 8, 12, 16};
        return t[c];
    endfunction : halves
    task automatic wr(input logic [7:0] a, input logic [15:0] w);
        @(posedge clock);
        reg_addr <= a;
        reg_wdata <= w;
        reg_wr <= 1'b1;
        @(posedge clock);
        reg_wr <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a);
        @(posedge clock);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clock);
        reg_rd <= 1'b0;
        #1 v = reg_rdata;
    endtask : rd
    // Two elements on one select, then the gap left to stretch
    task automatic run(input int l, input int g, input logic x);
        logic [1:0] cs;
        cs = 2'($urandom_range(3, 0));
        d = 8'($urandom);
        reply = 8'($urandom);
        nrise = 0;
        wr({6'h00, cs}, {10'h000, 3'(g), 3'(l)});
        wr(`QCT_ADDR_CTRL, {13'h0000, 2'b10, x});
        wr(`QCT_ADDR_TX, {6'h00, cs, ~d});
        for (int i = 0; i < 400 && nrise < 1; i++) @(posedge clock);
        wr(`QCT_ADDR_TX, {6'h00, cs, d});
        for (int i = 0; i < 900 && nrise < 16; i++) @(posedge clock);
        repeat (60) @(posedge clock);
        `CHK(cs_n[cs], 1'b0)
        `CHK(got, d)
        `CHK(oe, 1'b1)
        rd(`QCT_ADDR_STATUS);
        `CHK(v, 16'h0081)
        rd(`QCT_ADDR_RX);
        `CHK(v[7:0], reply)
        wr(`QCT_ADDR_CTRL, 16'h0000);
        repeat (4) @(posedge clock);
        `CHK(cs_n, 4'hF)
    endtask : run
    task automatic end_of_test;
        $display("compares %0d mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : end_of_test
    initial begin
        repeat (40000) @(posedge clock);
        mismatches++;
        end_of_test();
    end
    initial begin
        void'($urandom(32'h53F2E6B1));
        repeat (20) @(posedge clock);
        sys_rst <= 1'b0;
        // Option registers: reset value, full readback, unmapped place
        for (int a = 0; a < 4; a++) begin
            rd(8'(a));
            `CHK(v, {8'h00, `QCT_OPT_RESET})
            d = 8'($urandom);
            wr(8'(a), {8'h00, d});
            rd(8'(a));
            `CHK(v, {8'h00, d})
        end
        rd(8'h20);
        `CHK(v, 16'h0000)
        run(0, 0, 1'b0);
        bl = lead_cy;
        bg = gap_cy;
        for (int c = 1; c < 8; c++) begin
            run(c, 8 - c, 1'b0);
            `CHK((lead_cy - bl - 5 * halves(c)) inside {[-4:4]}, 1'b1)
            `CHK((gap_cy - bg - 5 * halves(8 - c)) inside {[-4:4]}, 1'b1)
        end
        run(3, 0, 1'b1);
        `CHK((gap_cy - bg - 5) inside {[-4:4]}, 1'b1)
        // Slave mode: no select, no clock drive
        wr(`QCT_ADDR_CTRL, 16'h0006);
        wr(`QCT_ADDR_TX, 16'h00A5);
        repeat (100) @(posedge clock);
        `CHK({oe, cs_n}, 5'h0F)
        end_of_test();
    end
endmodule : qct_cs_timing_tb
